// ==== design/pas_mdio_frame.sv ====
// Management serial frame parser and read-data driver.
// Assumes the management clock pin is slow and sampled by the core clock.
`timescale 1ns/1ps
module pas_mdio_frame (
    input wire logic core_clk_i, // Core clock
    input wire logic arst_n_i, // Async reset, active low
    input wire logic mdc_i, // Management clock pin
    input wire logic mdio_i, // Management data in
    output logic mdio_o, // Management data out
    output logic mdio_oe_o, // High while driving data pin
    output logic rd_stb_o, // Read request pulse
    output logic wr_stb_o, // Write request pulse
    output pas_pkg::pas_req_t req_o, // Address and write data
    input wire logic [15:0] rdata_i // Read data for request
);

    pas_pkg::pas_frame_state_t state;
    logic mdc_q;
    logic rise;
    logic [5:0] ones;
    logic [4:0] cnt;
    logic [12:0] hdr;
    logic [15:0] sh;
    logic hit;

    // ==========================================================
    // Clock edge detect
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            mdc_q <= 1'b0;
        else
            mdc_q <= mdc_i;
    end

    assign rise = mdc_i & ~mdc_q;
    // Only port addresses are answered
    assign hit = (hdr[9:5] >= pas_pkg::PHY_ADDR_FIRST) && (hdr[9:5] <= pas_pkg::PHY_ADDR_LAST);
    assign rd_stb_o = rise && (state == pas_pkg::FR_TURN) && (cnt == 5'h00)
                      && (hdr[11:10] == pas_pkg::OP_READ) && hit;
    assign wr_stb_o = rise && (state == pas_pkg::FR_DATA) && (cnt == pas_pkg::DATA_LAST)
                      && (hdr[11:10] == pas_pkg::OP_WRITE) && hit;
    assign req_o = '{phy: hdr[9:5], regad: hdr[4:0], data: {sh[14:0], mdio_i}};

    // ==========================================================
    // Frame sequencing on each management clock rise
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state <= pas_pkg::FR_PREAMBLE;
            ones <= 6'h00;
            cnt <= 5'h00;
            hdr <= 13'h0000;
            sh <= 16'h0000;
            mdio_o <= 1'b0;
            mdio_oe_o <= 1'b0;
        end
        else if (rise)
        begin
            unique case (state)
                pas_pkg::FR_PREAMBLE:
                begin
                    if (mdio_i)
                        ones <= (ones == pas_pkg::PREAMBLE_ONES) ? ones : ones + 6'h01;
                    else
                    begin
                        ones <= 6'h00;
                        cnt <= 5'h00;
                        if (ones == pas_pkg::PREAMBLE_ONES)
                            state <= pas_pkg::FR_HEADER;
                    end
                end
                pas_pkg::FR_HEADER:
                begin
                    hdr <= {hdr[11:0], mdio_i};
                    cnt <= cnt + 5'h01;
                    if (cnt == pas_pkg::HDR_LAST)
                    begin
                        cnt <= 5'h00;
                        // Start bit 1 and a known opcode, else drop the frame
                        if (hdr[11] && (hdr[10:9] == pas_pkg::OP_READ
                                        || hdr[10:9] == pas_pkg::OP_WRITE))
                            state <= pas_pkg::FR_TURN;
                        else
                            state <= pas_pkg::FR_PREAMBLE;
                    end
                end
                pas_pkg::FR_TURN:
                begin
                    if (cnt == 5'h00)
                    begin
                        cnt <= 5'h01;
                        if (rd_stb_o)
                        begin
                            sh <= rdata_i;
                            mdio_oe_o <= 1'b1;
                            mdio_o <= 1'b0;
                        end
                    end
                    else
                    begin
                        cnt <= 5'h00;
                        mdio_o <= sh[15];
                        state <= pas_pkg::FR_DATA;
                    end
                end
                pas_pkg::FR_DATA:
                begin
                    sh <= {sh[14:0], mdio_i};
                    mdio_o <= sh[14];
                    cnt <= cnt + 5'h01;
                    if (cnt == pas_pkg::DATA_LAST)
                    begin
                        mdio_oe_o <= 1'b0;
                        mdio_o <= 1'b0;
                        state <= pas_pkg::FR_PREAMBLE;
                    end
                end
            endcase
        end
    end

endmodule

// ==== design/pas_mode_enc.sv ====
// Operating mode encoder for one port.
// Assumes line state inputs synchronous to the core clock.
`timescale 1ns/1ps
module pas_mode_enc (
    input wire logic core_clk_i, // Core clock
    input wire logic arst_n_i, // Async reset, active low
    input wire pas_pkg::pas_line_t line_i, // Port line state
    output logic [2:0] mode_o // Registered mode code
);

    // ==========================================================
    // Mode resolution, isolation first
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            mode_o <= pas_pkg::MODE_RST;
        else if (line_i.isolate)
            mode_o <= pas_pkg::MODE_ISOLATED;
        else if (line_i.an_busy)
            mode_o <= pas_pkg::MODE_NEGOTIATING;
        else if (line_i.speed100)
            mode_o <= line_i.full_dup ? pas_pkg::MODE_100_FULL : pas_pkg::MODE_100_HALF;
        else
            mode_o <= line_i.full_dup ? pas_pkg::MODE_10_FULL : pas_pkg::MODE_10_HALF;
    end

endmodule

// ==== design/pas_phy_regs.sv ====
// Per-port management register subset: offered abilities, partner
// abilities, and the special control and status register.
// Assumes a station manager on the management serial pins and the
// port physical layers beside it, all synchronous to the core clock.
`timescale 1ns/1ps

module pas_phy_regs (
    input wire logic core_clk_i, // Core clock, 10 MHz
    input wire logic arst_n_i, // Async reset, active low
    input wire logic mdc_i, // Management clock pin
    input wire logic mdio_i, // Management data pin in
    output logic mdio_o, // Management data pin out
    output logic mdio_oe_o, // High while driving data pin
    input wire pas_pkg::pas_line_t [pas_pkg::PORT_COUNT-1:0] line_i, // Line state per port
    input wire logic [pas_pkg::PORT_COUNT-1:0] link_detect_i, // Raw link detect per port
    input wire pas_pkg::pas_cap_t [pas_pkg::PORT_COUNT-1:0] partner_i, // Announced abilities
    input wire logic [pas_pkg::PORT_COUNT-1:0] partner_stb_i, // Partner page received
    output pas_pkg::pas_cap_t [pas_pkg::PORT_COUNT-1:0] local_cap_o, // Abilities to offer
    output logic [pas_pkg::PORT_COUNT-1:0] force_link_pass_o, // Forced link pass
    output logic [pas_pkg::PORT_COUNT-1:0] link_pass_o, // Link treated as passing
    output logic [pas_pkg::PORT_COUNT-1:0] power_save_o, // Power save enable
    output logic [pas_pkg::PORT_COUNT-1:0] remote_loopback_o // Line loopback enable
);

    localparam int N = pas_pkg::PORT_COUNT;

    logic wr_stb;
    pas_pkg::pas_req_t req;
    logic [15:0] rdata;
    logic [2:0] idx;
    pas_pkg::pas_cap_t local_cap_q [N];
    pas_pkg::pas_cap_t partner_q [N];
    logic [1:0] rsvd_rw_q [N];
    logic [N-1:0] force_q;
    logic [N-1:0] power_save_q;
    logic [N-1:0] loopback_q;
    logic [N-1:0] pol_rev_q;
    logic [N-1:0] mdi_q;
    logic [2:0] mode_q [N];

    // ==========================================================
    // Helpers
    // Port index from management address, first port at 0x1
    function automatic logic [2:0] port_of(input logic [4:0] phy);
        logic [4:0] diff;
        diff = phy - pas_pkg::PHY_ADDR_FIRST;
        return diff[2:0];
    endfunction

    // Place an ability set into its register bit positions
    function automatic logic [15:0] cap_word(input pas_pkg::pas_cap_t cap);
        logic [15:0] w;
        w = 16'h0000;
        w[pas_pkg::CAP_PAUSE_BIT] = cap.pause;
        w[pas_pkg::CAP_F100_BIT] = cap.f100;
        w[pas_pkg::CAP_H100_BIT] = cap.h100;
        w[pas_pkg::CAP_F10_BIT] = cap.f10;
        w[pas_pkg::CAP_H10_BIT] = cap.h10;
        w[4:0] = pas_pkg::SELECTOR_VAL;
        return w;
    endfunction

    // ==========================================================
    // Serial frame handling
    pas_mdio_frame u_frame (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .mdc_i(mdc_i),
        .mdio_i(mdio_i),
        .mdio_o(mdio_o),
        .mdio_oe_o(mdio_oe_o),
        .rd_stb_o(), // Read strobe is consumed inside the parser
        .wr_stb_o(wr_stb),
        .req_o(req),
        .rdata_i(rdata)
    );

    assign idx = port_of(req.phy);

    // ==========================================================
    // Per-port mode encoders and sampled status flags
    for (genvar p = 0; p < N; p++)
    begin : g_port
        pas_mode_enc u_mode (
            .core_clk_i(core_clk_i),
            .arst_n_i(arst_n_i),
            .line_i(line_i[p]),
            .mode_o(mode_q[p])
        );
    end

    // Polarity and crossover status, sampled
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pol_rev_q <= '0;
            mdi_q <= '0;
        end
        else
        begin
            for (int p = 0; p < N; p++)
            begin
                pol_rev_q[p] <= line_i[p].pol_rev;
                mdi_q[p] <= line_i[p].mdi;
            end
        end
    end

    // ==========================================================
    // Offered abilities, software writable
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int p = 0; p < N; p++)
                local_cap_q[p] <= pas_pkg::LOCAL_CAP_RST;
        end
        else if (wr_stb && req.regad == pas_pkg::REG_LOCAL_CAP)
        begin
            // Only writable bits land; selector and reserved stay fixed
            local_cap_q[idx].pause <= req.data[pas_pkg::CAP_PAUSE_BIT];
            local_cap_q[idx].f100 <= req.data[pas_pkg::CAP_F100_BIT];
            local_cap_q[idx].h100 <= req.data[pas_pkg::CAP_H100_BIT];
            local_cap_q[idx].f10 <= req.data[pas_pkg::CAP_F10_BIT];
            local_cap_q[idx].h10 <= req.data[pas_pkg::CAP_H10_BIT];
        end
    end

    // ==========================================================
    // Partner abilities, captured from negotiation only
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int p = 0; p < N; p++)
                partner_q[p] <= pas_pkg::PARTNER_CAP_RST;
        end
        else
        begin
            // No management write path reaches these flops
            for (int p = 0; p < N; p++)
                if (partner_stb_i[p])
                    partner_q[p] <= partner_i[p];
        end
    end

    // ==========================================================
    // Special control bits
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            force_q <= '0;
            power_save_q <= '0;
            loopback_q <= '0;
            for (int p = 0; p < N; p++)
                rsvd_rw_q[p] <= pas_pkg::RSVD_RW_RST;
        end
        else if (wr_stb && req.regad == pas_pkg::REG_SPECIAL)
        begin
            // Mode, polarity and crossover bits are not written
            force_q[idx] <= req.data[pas_pkg::FORCE_LINK_BIT];
            power_save_q[idx] <= req.data[pas_pkg::POWER_SAVE_BIT];
            loopback_q[idx] <= req.data[pas_pkg::LOOPBACK_BIT];
            rsvd_rw_q[idx] <= req.data[pas_pkg::RSVD_RW_LSB +: 2];
        end
    end

    // ==========================================================
    // Controls toward the port
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            link_pass_o <= '0;
        else
            link_pass_o <= force_q | link_detect_i;
    end

    assign force_link_pass_o = force_q;
    assign power_save_o = power_save_q;
    assign remote_loopback_o = loopback_q;

    // Offered abilities toward negotiation
    always_comb
    begin
        for (int p = 0; p < N; p++)
            local_cap_o[p] = local_cap_q[p];
    end

    // ==========================================================
    // Read data, writable reserved bits read back, unlisted bits read zero
    always_comb
    begin
        rdata = 16'h0000;
        unique case (req.regad)
            pas_pkg::REG_LOCAL_CAP:
                rdata = cap_word(local_cap_q[idx]);
            pas_pkg::REG_PARTNER_CAP:
                rdata = cap_word(partner_q[idx]);
            pas_pkg::REG_SPECIAL:
            begin
                rdata[pas_pkg::MODE_LSB +: 3] = mode_q[idx];
                rdata[pas_pkg::RSVD_RW_LSB +: 2] = rsvd_rw_q[idx];
                rdata[pas_pkg::POL_REV_BIT] = pol_rev_q[idx];
                rdata[pas_pkg::MDI_BIT] = mdi_q[idx];
                rdata[pas_pkg::FORCE_LINK_BIT] = force_q[idx];
                rdata[pas_pkg::POWER_SAVE_BIT] = power_save_q[idx];
                rdata[pas_pkg::LOOPBACK_BIT] = loopback_q[idx];
            end
            default:
                rdata = 16'h0000;
        endcase
    end

endmodule

// ==== design/pas_pkg.sv ====
// Package for the per-port management register subset.
// Assumes one core clock; every file that uses it refers to it as pas_pkg::name.
package pas_pkg;

    // ==========================================================
    // Port addressing
    localparam int PORT_COUNT = 5;
    localparam logic [4:0] PHY_ADDR_FIRST = 5'h01;
    localparam logic [4:0] PHY_ADDR_LAST = 5'h05;

    // ==========================================================
    // Register offsets
    localparam logic [4:0] REG_LOCAL_CAP = 5'h04;
    localparam logic [4:0] REG_PARTNER_CAP = 5'h05;
    localparam logic [4:0] REG_SPECIAL = 5'h1F;

    // ==========================================================
    // Field positions
    localparam int CAP_PAUSE_BIT = 10;
    localparam int CAP_F100_BIT = 8;
    localparam int CAP_H100_BIT = 7;
    localparam int CAP_F10_BIT = 6;
    localparam int CAP_H10_BIT = 5;
    localparam int MODE_LSB = 8;
    localparam int RSVD_RW_LSB = 6;
    localparam int POL_REV_BIT = 5;
    localparam int MDI_BIT = 4;
    localparam int FORCE_LINK_BIT = 3;
    localparam int POWER_SAVE_BIT = 2;
    localparam int LOOPBACK_BIT = 1;
    localparam logic [4:0] SELECTOR_VAL = 5'h01;

    // ==========================================================
    // Reset values
    localparam logic [4:0] LOCAL_CAP_RST = 5'h1F;
    localparam logic [4:0] PARTNER_CAP_RST = 5'h00;
    localparam logic [1:0] RSVD_RW_RST = 2'h0;
    localparam logic [2:0] MODE_RST = 3'h0;

    // ==========================================================
    // Serial frame constants
    localparam logic [5:0] PREAMBLE_ONES = 6'h20;
    localparam logic [4:0] HDR_LAST = 5'h0C;
    localparam logic [4:0] DATA_LAST = 5'h0F;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;

    // Reported operating mode codes
    typedef enum logic [2:0] {
        MODE_NEGOTIATING = 3'h1,
        MODE_10_HALF = 3'h2,
        MODE_100_HALF = 3'h3,
        MODE_10_FULL = 3'h5,
        MODE_100_FULL = 3'h6,
        MODE_ISOLATED = 3'h7
    } pas_mode_t;

    // Frame parser states, Gray along the path
    typedef enum logic [1:0] {
        FR_PREAMBLE = 2'h0,
        FR_HEADER = 2'h1,
        FR_TURN = 2'h3,
        FR_DATA = 2'h2
    } pas_frame_state_t;

    // Duplex and pause abilities, offered or announced
    typedef struct packed {
        logic pause;
        logic f100;
        logic h100;
        logic f10;
        logic h10;
    } pas_cap_t;

    // Line state reported by the port's physical layer
    typedef struct packed {
        logic an_busy;
        logic isolate;
        logic speed100;
        logic full_dup;
        logic pol_rev;
        logic mdi;
    } pas_line_t;

    // Decoded management access
    typedef struct packed {
        logic [4:0] phy;
        logic [4:0] regad;
        logic [15:0] data;
    } pas_req_t;

endpackage

// ==== dv/pas_mgr_model.sv ====
// Station manager model driving the management clock and data pins.
// Assumes a pull-up on the data wire, resolved by the bench.
`timescale 1ns/1ps
module pas_mgr_model (
    input wire logic core_clk_i, // Core clock
    input wire logic mdio_i, // Resolved data wire
    output logic mdc_o, // Management clock, low when idle
    output logic mdio_o, // Data driven by manager
    output logic mdio_oe_o, // High while manager drives
    output logic rd_done_o, // Read finished pulse
    output logic [15:0] rd_data_o // Data of last read
);
    // ====
    // Idle pins; clock stands still between frames
    initial
    begin
        mdc_o = 1'b0;
        mdio_o = 1'b1;
        mdio_oe_o = 1'b0;
        rd_done_o = 1'b0;
        rd_data_o = 16'h0000;
    end

    // One clock period: data set while low, sampled before the rise
    task automatic tick(input logic b, output logic s);
        mdio_o = b;
        repeat (3) @(posedge core_clk_i);
        #1 s = mdio_i;
        mdc_o = 1'b1;
        repeat (3) @(posedge core_clk_i);
        #1 mdc_o = 1'b0;
    endtask

    // Whole frame with fresh preamble; read releases at turnaround
    task automatic xfer(input logic wr, input logic [4:0] phy, input logic [4:0] ra,
                        input logic [15:0] wd);
        logic [63:0] f;
        logic [15:0] rd;
        logic s;
        f = {32'hFFFF_FFFF, 2'b01, wr ? 2'b01 : 2'b10, phy, ra, 2'b10, wd};
        mdio_oe_o = 1'b1;
        for (int i = 63; i >= 0; i--)
        begin
            if (i == 17 && !wr)
                mdio_oe_o = 1'b0;
            tick(f[i], s);
            if (i < 16)
                rd = {rd[14:0], s};
        end
        mdio_oe_o = 1'b0;
        if (!wr)
        begin
            rd_data_o = rd;
            rd_done_o = 1'b1;
            @(posedge core_clk_i);
            #1 rd_done_o = 1'b0;
        end
    endtask
endmodule

// ==== dv/pas_phy_regs_chk.sv ====
// Concurrent checks on the register subset's top ports.
// Assumes one core clock and the async active-low reset.
`timescale 1ns/1ps
module pas_phy_regs_chk #(
    parameter int N = pas_pkg::PORT_COUNT
) (
    input wire logic core_clk_i, // Core clock
    input wire logic arst_n_i, // Async reset, active low
    input wire logic mdc_i, // Management clock
    input wire logic mdio_o, // Data out
    input wire logic mdio_oe_o, // Data drive enable
    input wire logic [N-1:0] link_detect_i, // Raw link detect
    input wire pas_pkg::pas_cap_t [N-1:0] local_cap_o, // Offered abilities
    input wire logic [N-1:0] force_link_pass_o, // Forced link
    input wire logic [N-1:0] link_pass_o, // Link pass
    input wire logic [N-1:0] power_save_o, // Power save
    input wire logic [N-1:0] remote_loopback_o // Loopback
);
    // ====
    // Clocking and properties
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    chk_link_pass_or: assert property (
        $past(arst_n_i) |-> link_pass_o == $past(force_link_pass_o | link_detect_i))
        else $error("link pass not force or detect");
    chk_one_port_ctl: assert property ($onehot0(
        (power_save_o ^ $past(power_save_o)) | (remote_loopback_o ^ $past(remote_loopback_o))
        | (force_link_pass_o ^ $past(force_link_pass_o))))
        else $error("controls of two ports changed");
    chk_reset_vals: assert property ($rose(arst_n_i) |->
        local_cap_o == {N{5'h1F}} && power_save_o == '0 && remote_loopback_o == '0)
        else $error("bad values after reset");
    chk_ta_low: assert property ($rose(mdio_oe_o) |-> !mdio_o)
        else $error("turnaround bit not low");
    chk_data_phase: assert property (
        mdio_oe_o && $past(mdio_oe_o) && $changed(mdio_o) |-> $past(mdc_i))
        else $error("read data moved off clock rise");
    chk_drive_min: assert property ($rose(mdio_oe_o) |-> mdio_oe_o [*8])
        else $error("read drive too short");
    chk_drive_gap: assert property ($fell(mdio_oe_o) |-> !mdio_oe_o [*8])
        else $error("read drive restarted too soon");
    chk_ctl_no_read: assert property (
        $changed({power_save_o, remote_loopback_o, local_cap_o}) |-> !mdio_oe_o)
        else $error("control changed during read");

    // Main scenarios
    cov_read: cover property ($rose(mdio_oe_o));
    cov_loop: cover property ($rose(|remote_loopback_o));
    cov_link: cover property ($rose(|link_pass_o));
endmodule

bind pas_phy_regs pas_phy_regs_chk i_chk (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .mdc_i(mdc_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .link_detect_i(link_detect_i),
    .local_cap_o(local_cap_o), .force_link_pass_o(force_link_pass_o),
    .link_pass_o(link_pass_o), .power_save_o(power_save_o),
    .remote_loopback_o(remote_loopback_o));

// ==== dv/tb_top.sv ====
// Self-checking bench for the register subset.
// Assumes the manager model and checker files compile before it.
`timescale 1ns/1ps
module tb_top;
    localparam int N = pas_pkg::PORT_COUNT;
    logic clk, rst_n, mdc, mdio_w, d_o, d_oe, m_o, m_oe, rd_done;
    logic [15:0] rd_data, wd;
    logic [N-1:0] det, pstb, flp, lp, ps, lb, m;
    pas_pkg::pas_line_t [N-1:0] line;
    pas_pkg::pas_cap_t [N-1:0] pcap, lcap, lexp;
    pas_pkg::pas_cap_t c;
    logic [3:0] ltab [6] = '{4'h8, 4'h0, 4'h2, 4'h1, 4'h3, 4'hC};
    logic [2:0] mtab [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
    logic [1:0] b;
    logic [15:0] q [$];
    int error_cnt, checks, p;

    // ====
    // Wire with pull-up, design and model
    assign mdio_w = d_oe ? d_o : (m_oe ? m_o : 1'b1);
    pas_phy_regs i_dut (.core_clk_i(clk), .arst_n_i(rst_n), .mdc_i(mdc), .mdio_i(mdio_w),
        .mdio_o(d_o), .mdio_oe_o(d_oe), .line_i(line), .link_detect_i(det),
        .partner_i(pcap), .partner_stb_i(pstb), .local_cap_o(lcap),
        .force_link_pass_o(flp), .link_pass_o(lp), .power_save_o(ps),
        .remote_loopback_o(lb));
    pas_mgr_model i_mgr (.core_clk_i(clk), .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(m_o),
        .mdio_oe_o(m_oe), .rd_done_o(rd_done), .rd_data_o(rd_data));

    // Clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ====
    // Tasks
    task automatic check(input string what, input logic [24:0] exp, input logic [24:0] got);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] exp);
        q.push_back(exp);
        i_mgr.xfer(1'b0, phy, ra, 16'h0000);
    endtask

    task automatic wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] d);
        i_mgr.xfer(1'b1, phy, ra, d);
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Read results against the oldest note
    always @(posedge clk)
    begin
        if (rd_done)
            check("read data", {9'h000, q.pop_front()}, {9'h000, rd_data});
    end

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end

    // ====
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        line = '0;
        det = '0;
        pcap = '0;
        pstb = '0;
        void'($urandom(36314));
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        p = 1 + $urandom % N;
        m = 5'h01 << (p - 1);
        check("local cap", {N{5'h1F}}, lcap);
        check("controls", 25'h0, {10'h000, flp, ps, lb});
        rd(5'(p), 5'h04, 16'h05E1);
        rd(5'(p), 5'h05, 16'h0001);
        done("reset");
        wd = 16'($urandom);
        wr(5'(p), 5'h04, wd);
        lexp = {N{5'h1F}};
        lexp[p-1] = {wd[10], wd[8:5]};
        check("local cap", lexp, lcap);
        rd(5'(p), 5'h04, (wd & 16'h05E0) | 16'h0001);
        done("offer");
        c = 5'($urandom);
        pcap[p-1] = c;
        pstb[p-1] = 1'b1;
        @(posedge clk);
        #1 pstb = '0;
        pcap = ~pcap;
        rd(5'(p), 5'h05, {5'h00, c[4], 1'b0, c[3:0], 5'h01});
        wr(5'(p), 5'h05, 16'hFFFF);
        rd(5'(p), 5'h05, {5'h00, c[4], 1'b0, c[3:0], 5'h01});
        done("partner");
        for (int i = 0; i < 6; i++)
        begin
            b = 2'($urandom);
            line[p-1] = {ltab[i], b};
            rd(5'(p), 5'h1F, {5'h00, mtab[i], 2'b00, b, 4'h0});
        end
        done("mode");
        for (int k = 3; k >= 1; k--)
        begin
            wr(5'(p), 5'h1F, 16'h0001 << k);
            check("controls", {10'h000, k == 3 ? m : 5'h00, k == 2 ? m : 5'h00,
                k == 1 ? m : 5'h00}, {10'h000, flp, ps, lb});
            check("link pass", {20'h00000, k == 3 ? m : 5'h00}, {20'h00000, lp});
        end
        wr(5'(p), 5'h1F, 16'hFFFF);
        det = 5'($urandom);
        repeat (2) @(posedge clk);
        #1 check("link pass", {20'h00000, det | m}, {20'h00000, lp});
        rd(5'(p), 5'h1F, {5'h00, 3'h7, 2'b11, b, 3'b111, 1'b0});
        done("control");
        rd(5'h00, 5'h1F, 16'hFFFF);
        wr(5'h06, 5'h04, 16'h0000);
        check("local cap", lexp, lcap);
        rd(5'(p), 5'h02, 16'h0000);
        done("refused");
        for (int i = 0; i < 10 && q.size() != 0; i++)
            @(posedge clk);
        check("reads left", 25'h0, 25'(q.size()));
        end_of_test();
    end
endmodule
